// file: logic/frame_timing_defines.vh
// Purpose: Constants of the frame timing unit and its low-power time keeper
// Assumes: APB slave, 32-bit data, 100 MHz pclk
// Notes:   Offsets are byte addresses of aligned words
`ifndef FRAME_TIMING_DEFINES_VH
`define FRAME_TIMING_DEFINES_VH

// Register byte offsets
`define REG_CTRL       8'h00
`define REG_WRAP       8'h04
`define REG_COUNT      8'h08
`define REG_EVT_IDX    8'h0c
`define REG_EVT_DATA   8'h10
`define REG_IRQ_STAT   8'h14
`define REG_IRQ_CLR    8'h18
`define REG_IRQ_EN     8'h1c
`define REG_CAL_PER    8'h20
`define REG_CAL_RES    8'h24
`define REG_LP_STEP    8'h28
`define REG_LP_STAT    8'h2c

// Control fields
`define CTRL_RUN       0
`define CTRL_FORCE     1
`define CTRL_LP_REQ    2
`define CTRL_CAL_GO    3

// Event entry fields
`define EVT_DATE_MSB   15
`define EVT_ACT_LSB    16
`define EVT_ACT_MSB    19
`define EVT_VALID      31
`define EVT_ENTRIES    60

// Interrupt status bits
`define IRQ_FRAME      0
`define IRQ_CAL        1
`define IRQ_WAKE       2
`define IRQ_BITS       3

// Reset values
`define WRAP_RESET     16'h1387
`define LP_STEP_RESET  16'h2110

// Quarter-bit rate 13/12 MHz from the system clock
`define SYS_CLK_MHZ    100
`define TICK_NUM       13
`define TICK_MOD       (`SYS_CLK_MHZ * 12)

// Wait for the system clock to settle after leaving low power
`define WAKE_TIME_NS   10000
`define WAKE_CYCLES    ((`WAKE_TIME_NS * `SYS_CLK_MHZ) / 1000)

// Calibration resolution in system clocks
`define CAL_DIV        4

`endif

// file: logic/frame_timing_unit.v
// Purpose: Frame timing unit with event table and low-power time keeper
// Assumes: APB slave on pclk; lp_clk_32k and wake_in synchronous to pclk
// Notes:   sys_clk_stop asks the clock controller to halt the system clock
//
// How it works
// - Quarter-bit counter advances at 13/12 MHz from the system clock
// - Counter wraps to zero at the wrap value and raises frame interrupt
// - Software reads the live counter without disturbing it
// - A new wrap value is accepted anytime and applied at next wrap
// - Outside low power, an active event fires when the counter equals its date
// - Programming and active tables; only active entries are compared
// - On wrap the programming table is copied into the active table
// - A force request copies the programming table at once
// - Sixty entries, each a date paired with an action
// - Frame interrupt can be masked so frames pass silently
// - In low power the time base advances on 32 kHz edges
// - Slow clock calibrated over a programmed period to 4 clocks
// - A state machine walks the power-up after low power exit
//
// The APB interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "frame_timing_defines.vh"

module frame_timing_unit (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire        lp_clk_32k,
  input  wire        wake_in,
  output reg  [15:0] event_out,
  output reg         irq,
  output reg         sys_clk_stop
);

  // Power states
  localparam [1:0] ST_RUN   = 2'd0;
  localparam [1:0] ST_SLEEP = 2'd1;
  localparam [1:0] ST_WAKE  = 2'd2;
  localparam [1:0] ST_SYNC  = 2'd3;

  ////////////////////////////////////////////////////////////////////////////
  // Advances a count by a step, wrapping past the limit; msb flags a wrap
  function [16:0] next_count;
    input [15:0] cnt;
    input [15:0] step;
    input [15:0] limit;
    reg   [16:0] sum;
    begin
      sum = {1'b0, cnt} + {1'b0, step};
      if (sum > {1'b0, limit}) begin
        next_count = {1'b1, sum[15:0] - limit - 16'h0001};
      end else begin
        next_count = {1'b0, sum[15:0]};
      end
    end
  endfunction

  // Control and configuration
  reg         run_q;
  reg         force_q;
  reg         lp_req_q;
  reg         cal_go_q;
  reg  [15:0] wrap_pend_q;
  reg  [15:0] wrap_act_q;
  reg  [5:0]  evt_idx_q;
  reg  [15:0] cal_per_q;
  reg  [15:0] lp_step_q;
  reg  [`IRQ_BITS-1:0] irq_stat_q;
  reg  [`IRQ_BITS-1:0] irq_en_q;

  // Time base
  reg  [10:0] frac_q;
  reg  [15:0] count_q;
  reg  [7:0]  lp_frac_q;
  reg         tick_q;

  // Event tables
  reg  [15:0] prog_date [0:`EVT_ENTRIES-1];
  reg  [3:0]  prog_act  [0:`EVT_ENTRIES-1];
  reg         prog_vld  [0:`EVT_ENTRIES-1];
  reg  [15:0] act_date  [0:`EVT_ENTRIES-1];
  reg  [3:0]  act_act   [0:`EVT_ENTRIES-1];
  reg         act_vld   [0:`EVT_ENTRIES-1];

  // Power sequencing
  reg  [1:0]  pstate_q;
  reg  [9:0]  wake_cnt_q;
  reg         slow_prev_q;

  // Calibrator outputs
  wire        cal_busy;
  wire        cal_done;
  wire [23:0] cal_res;

  // Decoded strobes
  wire        wr_en;
  wire        setup;
  wire        slow_rise;
  wire        in_sleep;
  wire [16:0] run_next;
  wire [16:0] lp_next;
  wire [8:0]  lp_sum;
  wire        frame_wrap;
  wire        do_copy;
  wire [`IRQ_BITS-1:0] irq_set;
  wire [`IRQ_BITS-1:0] irq_clr;
  wire [31:0] frac_sum  = {21'h0, frac_q} + `TICK_NUM;
  wire [31:0] frac_wrap = frac_sum - `TICK_MOD;
  wire [31:0] wake_load = `WAKE_CYCLES - 1;

  integer i, j;

  ////////////////////////////////////////////////////////////////////////////
  // Bus strobes and time base arithmetic
  assign setup     = psel & ~penable;
  assign wr_en     = psel & penable & pready & pwrite;
  assign slow_rise = lp_clk_32k & ~slow_prev_q;
  assign in_sleep  = (pstate_q == ST_SLEEP);
  assign run_next  = next_count(count_q, 16'h0001, wrap_act_q);
  assign lp_sum    = {1'b0, lp_frac_q} + {1'b0, lp_step_q[7:0]};
  assign lp_next   = next_count(count_q,
                                {8'h00, lp_step_q[15:8]} +
                                {15'h0, lp_sum[8]},
                                wrap_act_q);
  assign frame_wrap = (tick_q && run_q && !in_sleep && run_next[16]) ||
                      (slow_rise && in_sleep && lp_next[16]);
  assign do_copy   = frame_wrap || force_q;

  // Interrupt events and write-one clears
  assign irq_set = {(pstate_q == ST_SYNC) && slow_rise, cal_done,
                    frame_wrap};
  assign irq_clr = (wr_en && paddr == `REG_IRQ_CLR) ?
                   pwdata[`IRQ_BITS-1:0] : {`IRQ_BITS{1'b0}};

  ////////////////////////////////////////////////////////////////////////////
  // Slow clock calibration
  slow_clock_calibrator u_cal (
    .clk       (pclk),
    .rst_n     (presetn),
    .start     (cal_go_q),
    .period    (cal_per_q),
    .slow_rise (slow_rise),
    .busy_q    (cal_busy),
    .done_q    (cal_done),
    .result_q  (cal_res)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fractional divider: 13 of every 1200 system clocks give a tick
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frac_q <= 11'h000;
      tick_q <= 1'b0;
    end else begin
      if (frac_sum >= `TICK_MOD) begin
        frac_q <= frac_wrap[10:0];
        tick_q <= 1'b1;
      end else begin
        frac_q <= frac_sum[10:0];
        tick_q <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter, wrap limit and low-power accumulation
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q     <= 16'h0000;
      wrap_act_q  <= `WRAP_RESET;
      lp_frac_q   <= 8'h00;
      slow_prev_q <= 1'b0;
    end else begin
      slow_prev_q <= lp_clk_32k;
      if (in_sleep) begin
        if (slow_rise) begin
          lp_frac_q <= lp_sum[7:0];
          count_q   <= lp_next[15:0];
        end
      end else if (tick_q && run_q) begin
        count_q <= run_next[15:0];
      end
      if (frame_wrap) begin
        wrap_act_q <= wrap_pend_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Active table: match, pulse, clear; reload from the programming table
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_out <= 16'h0000;
      for (i = 0; i < `EVT_ENTRIES; i = i + 1) begin
        act_date[i] <= 16'h0000;
        act_act[i]  <= 4'h0;
        act_vld[i]  <= 1'b0;
      end
    end else begin
      event_out <= 16'h0000;
      for (i = 0; i < `EVT_ENTRIES; i = i + 1) begin
        if (do_copy) begin
          act_date[i] <= prog_date[i];
          act_act[i]  <= prog_act[i];
          act_vld[i]  <= prog_vld[i];
        end else if (tick_q && run_q && !in_sleep && act_vld[i] &&
                     act_date[i] == count_q) begin
          act_vld[i] <= 1'b0;
        end
        if (tick_q && run_q && !in_sleep && act_vld[i] &&
            act_date[i] == count_q) begin
          event_out[act_act[i]] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Programming table written one entry at a time through the index
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (j = 0; j < `EVT_ENTRIES; j = j + 1) begin
        prog_date[j] <= 16'h0000;
        prog_act[j]  <= 4'h0;
        prog_vld[j]  <= 1'b0;
      end
    end else if (wr_en && paddr == `REG_EVT_DATA &&
                 {26'h0, evt_idx_q} < `EVT_ENTRIES) begin
      prog_date[evt_idx_q] <= pwdata[`EVT_DATE_MSB:0];
      prog_act[evt_idx_q]  <= pwdata[`EVT_ACT_MSB:`EVT_ACT_LSB];
      prog_vld[evt_idx_q]  <= pwdata[`EVT_VALID];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power sequencer: sleep on request, wake on pin, settle, resync to 32k
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pstate_q     <= ST_RUN;
      wake_cnt_q   <= 10'h000;
      sys_clk_stop <= 1'b0;
    end else begin
      case (pstate_q)
        ST_RUN: begin
          if (lp_req_q) begin
            pstate_q     <= ST_SLEEP;
            sys_clk_stop <= 1'b1;
          end
        end
        ST_SLEEP: begin
          if (wake_in) begin
            pstate_q     <= ST_WAKE;
            sys_clk_stop <= 1'b0;
            wake_cnt_q   <= wake_load[9:0];
          end
        end
        ST_WAKE: begin
          if (wake_cnt_q == 10'h000) begin
            pstate_q <= ST_SYNC;
          end else begin
            wake_cnt_q <= wake_cnt_q - 10'h001;
          end
        end
        ST_SYNC: begin
          if (slow_rise) begin
            pstate_q <= ST_RUN;
          end
        end
        default: begin
          pstate_q     <= ST_RUN;
          sys_clk_stop <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers and sticky interrupt status
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_q       <= 1'b0;
      force_q     <= 1'b0;
      lp_req_q    <= 1'b0;
      cal_go_q    <= 1'b0;
      wrap_pend_q <= `WRAP_RESET;
      evt_idx_q   <= 6'h00;
      cal_per_q   <= 16'h0000;
      lp_step_q   <= `LP_STEP_RESET;
      irq_en_q    <= {`IRQ_BITS{1'b0}};
      irq_stat_q  <= {`IRQ_BITS{1'b0}};
      irq         <= 1'b0;
    end else begin
      force_q  <= 1'b0;
      cal_go_q <= 1'b0;
      if (pstate_q == ST_SYNC && slow_rise) begin
        lp_req_q <= 1'b0;
      end
      if (wr_en) begin
        case (paddr)
          `REG_CTRL: begin
            run_q    <= pwdata[`CTRL_RUN];
            force_q  <= pwdata[`CTRL_FORCE];
            lp_req_q <= pwdata[`CTRL_LP_REQ];
            cal_go_q <= pwdata[`CTRL_CAL_GO];
          end
          `REG_WRAP:    wrap_pend_q <= pwdata[15:0];
          `REG_EVT_IDX: evt_idx_q   <= pwdata[5:0];
          `REG_CAL_PER: cal_per_q   <= pwdata[15:0];
          `REG_LP_STEP: lp_step_q   <= pwdata[15:0];
          `REG_IRQ_EN:  irq_en_q    <= pwdata[`IRQ_BITS-1:0];
          default: begin
          end
        endcase
      end
      // A new event in the clearing cycle survives
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
      irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_en_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: data captured in setup, ready in the access cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= 1'b0;
      if (setup) begin
        prdata <= 32'h00000000;
        case (paddr)
          `REG_CTRL:     prdata <= {28'h0000000, cal_busy, lp_req_q,
                                    1'b0, run_q};
          `REG_WRAP:     prdata <= {16'h0000, wrap_pend_q};
          `REG_COUNT:    prdata <= {16'h0000, count_q};
          `REG_EVT_IDX:  prdata <= {26'h0000000, evt_idx_q};
          `REG_EVT_DATA: begin
            if ({26'h0, evt_idx_q} < `EVT_ENTRIES) begin
              prdata <= {prog_vld[evt_idx_q], 11'h000,
                         prog_act[evt_idx_q], prog_date[evt_idx_q]};
            end
          end
          `REG_IRQ_STAT: prdata <= {29'h00000000, irq_stat_q};
          `REG_IRQ_CLR:  prdata <= 32'h00000000;
          `REG_IRQ_EN:   prdata <= {29'h00000000, irq_en_q};
          `REG_CAL_PER:  prdata <= {16'h0000, cal_per_q};
          `REG_CAL_RES:  prdata <= {8'h00, cal_res};
          `REG_LP_STEP:  prdata <= {16'h0000, lp_step_q};
          `REG_LP_STAT:  prdata <= {29'h00000000, sys_clk_stop, pstate_q};
          default:       pslverr <= 1'b1;
        endcase
      end
    end
  end

endmodule // frame_timing_unit
`default_nettype wire

// file: logic/slow_clock_calibrator.v
// Purpose: Measures a number of 32 kHz periods in units of 4 system clocks
// Assumes: slow_rise is a one-cycle pulse on each slow clock rising edge
// Notes:   Measurement opens and closes on slow clock edges
`timescale 1ns/1ps
`default_nettype none
`include "frame_timing_defines.vh"

module slow_clock_calibrator (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        start,
  input  wire [15:0] period,
  input  wire        slow_rise,
  output reg         busy_q,
  output reg         done_q,
  output reg  [23:0] result_q
);

  reg         armed_q;
  reg  [15:0] left_q;
  reg  [1:0]  pre_q;
  wire [31:0] pre_last = `CAL_DIV - 1;

  ////////////////////////////////////////////////////////////////////////////
  // Arm on start, open at next slow edge, count sysclk/4 until period ends
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_q  <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      left_q   <= 16'h0000;
      pre_q    <= 2'h0;
      result_q <= 24'h000000;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q && period != 16'h0000) begin
        armed_q <= 1'b1;
      end else if (armed_q && slow_rise) begin
        armed_q  <= 1'b0;
        busy_q   <= 1'b1;
        left_q   <= period;
        pre_q    <= 2'h0;
        result_q <= 24'h000000;
      end else if (busy_q) begin
        pre_q <= pre_q + 2'h1;
        if (pre_q == pre_last[1:0]) begin
          result_q <= result_q + 24'h000001;
        end
        if (slow_rise) begin
          if (left_q == 16'h0001) begin
            busy_q <= 1'b0;
            done_q <= 1'b1;
          end
          left_q <= left_q - 16'h0001;
        end
      end
    end
  end

endmodule // slow_clock_calibrator
`default_nettype wire

// file: tb/frame_timing_unit_sva.sv
// Purpose: Port assertions for the frame timing unit
// Assumes: Zero-wait APB, ticks far apart, irq registered from status
// Notes:   Attached to every frame_timing_unit by bind
`timescale 1ns/1ps
`default_nettype none
module frame_timing_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        wake_in,
  input wire logic [15:0] event_out,
  input wire logic        irq,
  input wire logic        sys_clk_stop
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  ////////////////////////////////////////////////////////////////////////
  // Completed write strobe
  wire acc_wr = psel & penable & pready & pwrite;
  ////////////////////////////////////////////////////////////////////////
  // Bus answers
  a_ready_after_setup: assert property (
    psel && !penable |=> pready) else $error("pready missing");
  a_ready_one_cycle: assert property (
    pready |=> !pready) else $error("pready too long");
  a_unmapped_error: assert property (
    psel && !penable && paddr > 8'h2c |=> pslverr && pready)
    else $error("no error on unmapped");
  // Events and interrupts
  a_event_single: assert property (
    event_out != 16'h0000 |=> (event_out == 16'h0000)[*8])
    else $error("event pulse too long");
  a_mask_drops_irq: assert property (
    acc_wr && paddr == 8'h1c && pwdata == 32'h0 |-> ##2 !irq)
    else $error("masked irq stays");
  a_clear_drops_irq: assert property (
    acc_wr && paddr == 8'h18 && pwdata == 32'h7 |-> ##2 !irq)
    else $error("cleared irq stays");
  // Low power
  a_sleep_stop: assert property (
    acc_wr && paddr == 8'h00 && pwdata[2] |-> ##[1:3] sys_clk_stop)
    else $error("no clock stop");
  a_stop_wake: assert property (
    $fell(sys_clk_stop) |-> $past(wake_in)) else $error("wake unasked");
  a_reset_quiet: assert property (
    @(posedge pclk) disable iff (1'b0)
    !presetn |-> !irq && !sys_clk_stop && event_out == 16'h0000)
    else $error("outputs busy in reset");
endmodule // frame_timing_checker
bind frame_timing_unit frame_timing_checker chk_u (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .wake_in(wake_in), .event_out(event_out),
  .irq(irq), .sys_clk_stop(sys_clk_stop));
`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench of the frame timing unit
// Assumes: Slow clock is a data input toggled every 150 pclk cycles
// Notes:   First frame runs to the reset wrap limit before a new one applies
`timescale 1ns/1ps
`default_nettype none
`include "frame_timing_defines.vh"
module tb;
  logic        pclk, presetn, psel, penable, pwrite, lp_clk_32k, wake_in;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, c1;
  logic        pready, pslverr, irq, sys_clk_stop, err;
  logic [15:0] event_out;
  int          errors, samples_checked, lp_div, n;
  frame_timing_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .lp_clk_32k(lp_clk_32k), .wake_in(wake_in), .event_out(event_out),
    .irq(irq), .sys_clk_stop(sys_clk_stop));
  ////////////////////////////////////////////////////////////////////////
  // Clocks: pclk 100 MHz, slow clock period 300 pclk cycles
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    lp_div <= (lp_div == 149) ? 0 : lp_div + 1;
    if (lp_div == 149) lp_clk_32k <= ~lp_clk_32k;
  end
  ////////////////////////////////////////////////////////////////////////
  // Reporting and compares
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk_eq(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_in(input logic [31:0] g, input int lo, input int hi);
    samples_checked++;
    if (^g === 1'bx || g < lo || g > hi) begin
      errors++;
      $display("MISMATCH t=%0t %0d not in %0d..%0d", $time, g, lo, hi);
    end
  endtask
  // APB transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    if (n >= 50) wait_on(3, 0);
  endtask
  // Bounded wait: 0 irq high, 1 event pulse, 2 clock stop low
  function automatic logic hit(input int s);
    if (s == 0) return irq === 1'b1;
    if (s == 1) return event_out !== 16'h0000;
    return sys_clk_stop === 1'b0;
  endfunction
  task wait_on(input int s, input int max);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (!hit(s) && n < max);
    if (n >= max) begin
      errors++;
      $display("MISMATCH t=%0t wait %0d timed out", $time, s);
      tally_and_finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_reset;
    apb(0, `REG_WRAP, 0);
    chk_eq(rd, 32'h00001387);
    apb(0, `REG_LP_STEP, 0);
    chk_eq(rd, 32'h00002110);
    apb(0, 8'h30, 0);
    chk_eq(err, 1'b1);
    $display("test reset done");
  endtask
  task t_calib;
    apb(1, `REG_CAL_PER, 4);
    apb(1, `REG_IRQ_EN, 2);
    apb(1, `REG_CTRL, 8);
    wait_on(0, 3000);
    apb(0, `REG_CAL_RES, 0);
    chk_in(rd, 299, 301);
    apb(1, `REG_IRQ_CLR, 7);
    $display("test calib done");
  endtask
  task t_frame;
    apb(1, `REG_WRAP, 9);
    apb(1, `REG_IRQ_EN, 1);
    // First 5000-count frame passes in sleep at 250 counts a slow tick
    apb(1, `REG_LP_STEP, 32'hfa00);
    apb(1, `REG_CTRL, 5);
    wait_on(0, 7000);
    apb(0, `REG_COUNT, 0);
    chk_in(rd, 0, 1);
    wake_in <= 1;
    wait_on(2, 100);
    wake_in <= 0;
    apb(1, `REG_IRQ_CLR, 7);
    wait_on(0, 1200);
    apb(1, `REG_IRQ_CLR, 7);
    wait_on(0, 1200);
    chk_in(n, 890, 935);
    apb(0, `REG_COUNT, 0);
    chk_in(rd, 0, 9);
    apb(0, `REG_IRQ_STAT, 0);
    chk_eq(rd[0], 1'b1);
    apb(1, `REG_IRQ_CLR, 1);
    apb(0, `REG_IRQ_STAT, 0);
    chk_eq(rd[0], 1'b0);
    apb(1, `REG_IRQ_EN, 0);
    repeat (1000) @(posedge pclk);
    chk_eq(irq, 1'b0);
    apb(0, `REG_IRQ_STAT, 0);
    chk_eq(rd[0], 1'b1);
    apb(1, `REG_IRQ_CLR, 1);
    apb(1, `REG_IRQ_EN, 1);
    $display("test frame done");
  endtask
  task t_events;
    wait_on(0, 1200);
    apb(1, `REG_IRQ_CLR, 1);
    apb(1, `REG_EVT_IDX, 0);
    apb(1, `REG_EVT_DATA, 32'h80050003);
    apb(1, `REG_EVT_IDX, 59);
    apb(1, `REG_EVT_DATA, 32'h800f0007);
    apb(1, `REG_EVT_IDX, 60);
    apb(1, `REG_EVT_DATA, 32'h80010001);
    apb(0, `REG_EVT_DATA, 0);
    chk_eq(rd, 32'h0);
    apb(1, `REG_CTRL, 3);
    wait_on(1, 1000);
    chk_eq(event_out, 16'h0020);
    wait_on(1, 1000);
    chk_eq(event_out, 16'h8000);
    wait_on(0, 1200);
    apb(1, `REG_IRQ_CLR, 1);
    apb(1, `REG_EVT_IDX, 0);
    apb(1, `REG_EVT_DATA, 32'h80030003);
    wait_on(1, 1000);
    chk_eq(event_out, 16'h0020);
    wait_on(1, 1000);
    chk_eq(event_out, 16'h8000);
    wait_on(1, 1000);
    chk_eq(event_out, 16'h0008);
    $display("test events done");
  endtask
  task t_lowpower;
    apb(1, `REG_LP_STEP, 32'h100);
    apb(1, `REG_IRQ_CLR, 7);
    apb(1, `REG_IRQ_EN, 4);
    apb(1, `REG_CTRL, 5);
    apb(0, `REG_LP_STAT, 0);
    chk_eq(rd[2:0], 3'h5);
    apb(0, `REG_COUNT, 0);
    c1 = rd;
    repeat (900) @(posedge pclk);
    apb(0, `REG_COUNT, 0);
    chk_eq(rd !== c1, 1'b1);
    wake_in <= 1;
    wait_on(2, 100);
    wake_in <= 0;
    wait_on(0, 3000);
    apb(0, `REG_LP_STAT, 0);
    chk_eq(rd[2:0], 3'h0);
    $display("test lowpower done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {psel, penable, pwrite, wake_in, lp_clk_32k} = 5'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1;
    lp_div = 0;
    errors = 0;
    samples_checked = 0;
    // Falling edge resets the design before the first clock edge
    #1 presetn = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_calib;
    t_frame;
    t_events;
    t_lowpower;
    tally_and_finish;
  end
endmodule // tb
`default_nettype wire
